//--- sccr_pkg.sv
// sccr_pkg.sv - constants, types and state names for the system control
// coprocessor register bank.
// assumes: used by sccr_regs, its two leaf modules, the checker and the bench.
//
// Behaviour
// - decode sixteen register numbers, some shared
// - shared numbers pick function by variant strap, selectors
// - mmu control/base/domain/fault registers store, read back
// - any cache operation write invalidates whole cache
// - tlb operation write of zero flushes tlb
// - tlb write with bit0 set flushes one entry
// - process identifier register stores and reads back
// - protection control registers are plain storage
// - region definition holds base, size, enable together
// - eight region definitions chosen by region index
package sccr_pkg;

  // ---------------------------------------------------------------
  // register numbers
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_IDENT = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_TBASE = 4'h2;
  localparam logic [3:0] REG_DOMAIN = 4'h3;
  localparam logic [3:0] REG_FSTAT = 4'h5;
  localparam logic [3:0] REG_FADDR = 4'h6;
  localparam logic [3:0] REG_CACHE_OP = 4'h7;
  localparam logic [3:0] REG_TLB_OP = 4'h8;
  localparam logic [3:0] REG_PROC_ID = 4'hd;

  // ---------------------------------------------------------------
  // region definition layout and reset values
  // ---------------------------------------------------------------
  localparam int REGION_COUNT = 8;
  localparam int REGION_EN_BIT = 0;
  localparam int REGION_SIZE_LSB = 1;
  localparam int REGION_SIZE_MSB = 5;
  localparam int REGION_BASE_LSB = 12;
  localparam logic [31:0] REGION_MASK = 32'hffff_f03f;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // tlb entry whose single-entry flush bit is bit 0
  localparam int TLB_SINGLE_BIT = 0;
  localparam logic [31:0] TLB_VA_MASK = 32'hffff_fffe;

  // ---------------------------------------------------------------
  // transfer carrier and cache/tlb operation carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] num;
    logic [31:0] data;
  } sccr_req_t;

  typedef struct packed {
    logic cache_inval_all;
    logic tlb_inval_all;
    logic tlb_inval_one;
    logic [31:0] tlb_va;
  } sccr_ops_t;

  typedef enum logic [1:0] {
    SCCR_IDLE,
    SCCR_ANSWER
  } sccr_state_t;

endpackage

//--- sccr_region_bank.sv
// sccr_region_bank.sv - eight region definitions for the protection unit.
// assumes: write strobe and index come from the register bank on the
// same clock.
`timescale 1ns/1ps
`default_nettype none
module sccr_region_bank (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // access
  input wire logic wr_i,
  input wire logic [2:0] index_i,
  input wire logic [31:0] wdata_i,
  // read port
  output logic [31:0] rdata_o
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [31:0] region [sccr_pkg::REGION_COUNT]; // base/size/enable words
  logic [31:0] next_region [sccr_pkg::REGION_COUNT];

  // one entry per region; only the indexed one takes the word
  genvar g;
  generate
    for (g = 0; g < sccr_pkg::REGION_COUNT; g++) begin : g_region
      // base, size and enable move as one word
      always_comb begin
        next_region[g] = region[g];
        if (wr_i && index_i == 3'(g)) begin
          next_region[g] = wdata_i & sccr_pkg::REGION_MASK;
        end
      end
      always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
          region[g] <= sccr_pkg::RESET_WORD;
        end else begin
          region[g] <= next_region[g];
        end
      end
    end
  endgenerate

  // index selects the read word too
  assign rdata_o = region[index_i];

endmodule
`default_nettype wire

//--- sccr_op_decode.sv
// sccr_op_decode.sv - turns writes to the operation registers into
// one-cycle cache and tlb invalidate pulses.
// assumes: wr strobes are single-cycle from the register bank.
`timescale 1ns/1ps
`default_nettype none
module sccr_op_decode (
  // write strobes
  input wire logic cache_wr_i,
  input wire logic tlb_wr_i,
  input wire logic [31:0] wdata_i,
  // decoded operation
  output sccr_pkg::sccr_ops_t ops_o
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  always_comb begin
    ops_o = '0;
    // value is ignored: every write flushes the whole cache
    ops_o.cache_inval_all = cache_wr_i;
    if (tlb_wr_i) begin
      if (wdata_i[sccr_pkg::TLB_SINGLE_BIT]) begin
        ops_o.tlb_inval_one = 1'b1;
        ops_o.tlb_va = wdata_i & sccr_pkg::TLB_VA_MASK;
      end else if (wdata_i == sccr_pkg::RESET_WORD) begin
        ops_o.tlb_inval_all = 1'b1;
      end
      // other even nonzero values have no defined meaning: ignored
    end
  end

endmodule
`default_nettype wire

//--- sccr_regs.sv
// sccr_regs.sv - system control coprocessor register bank, top level.
// assumes: the core issues at most one transfer per cycle on core_clk_i;
// variant and process-id presence are static inputs from the core.
`timescale 1ns/1ps
`default_nettype none
module sccr_regs #(
  // identification word; value is arbitrary
  parameter logic [31:0] ID_VALUE = 32'h0000_1234
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // configuration straps, static while running
  input wire logic prot_variant_i,
  input wire logic pid_present_i,
  // selectors
  input wire logic cache_side_selector_i,
  input wire logic [2:0] region_index_selector_i,
  // coprocessor transfer request
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [3:0] req_num_i,
  input wire logic [31:0] req_wdata_i,
  // read answer
  output logic rsp_valid_o,
  output logic [31:0] rsp_rdata_o,
  // cache and tlb maintenance pulses
  output logic cache_inval_all_o,
  output logic tlb_inval_all_o,
  output logic tlb_inval_one_o,
  output logic [31:0] tlb_inval_va_o,
  // live control word for the core
  output logic [31:0] system_control_o
);

  // ---------------------------------------------------------------
  // request carrier
  // ---------------------------------------------------------------
  sccr_pkg::sccr_req_t req; // bundled transfer from the core
  assign req.valid = req_valid_i;
  assign req.write = req_write_i;
  assign req.num = req_num_i;
  assign req.data = req_wdata_i;

  logic wr; // write this cycle
  assign wr = req.valid && req.write;

  // ---------------------------------------------------------------
  // stored registers
  // ---------------------------------------------------------------
  logic [31:0] system_control; // shared by both variants
  logic [31:0] table_base_or_cache_ctrl;
  logic [31:0] domain_or_buffer_ctrl;
  logic [31:0] fault_status_or_protection;
  logic [31:0] prefetch_fault_status; // second side of fault status
  logic [31:0] fault_address;
  logic [31:0] process_identifier;
  logic [31:0] next_system_control;
  logic [31:0] next_table_base_or_cache_ctrl;
  logic [31:0] next_domain_or_buffer_ctrl;
  logic [31:0] next_fault_status_or_protection;
  logic [31:0] next_prefetch_fault_status;
  logic [31:0] next_fault_address;
  logic [31:0] next_process_identifier;

  // write decode; identification and unknown numbers fall through
  always_comb begin
    next_system_control = system_control;
    next_table_base_or_cache_ctrl = table_base_or_cache_ctrl;
    next_domain_or_buffer_ctrl = domain_or_buffer_ctrl;
    next_fault_status_or_protection = fault_status_or_protection;
    next_prefetch_fault_status = prefetch_fault_status;
    next_fault_address = fault_address;
    next_process_identifier = process_identifier;
    if (wr) begin
      case (req.num)
        sccr_pkg::REG_CTRL: begin
          next_system_control = req.data;
        end
        sccr_pkg::REG_TBASE: begin
          next_table_base_or_cache_ctrl = req.data;
        end
        sccr_pkg::REG_DOMAIN: begin
          next_domain_or_buffer_ctrl = req.data;
        end
        sccr_pkg::REG_FSTAT: begin
          // mmu side selector picks data or prefetch fault status
          if (!prot_variant_i && cache_side_selector_i) begin
            next_prefetch_fault_status = req.data;
          end else begin
            next_fault_status_or_protection = req.data;
          end
        end
        sccr_pkg::REG_FADDR: begin
          // protection variant routes to the region bank instead
          if (!prot_variant_i) begin
            next_fault_address = req.data;
          end
        end
        sccr_pkg::REG_PROC_ID: begin
          if (pid_present_i && !prot_variant_i) begin
            next_process_identifier = req.data;
          end
        end
        default: begin
          // identification and unmapped numbers: write dropped
          next_system_control = system_control;
        end
      endcase
    end
  end

  // register the stored values
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      system_control <= sccr_pkg::RESET_WORD;
      table_base_or_cache_ctrl <= sccr_pkg::RESET_WORD;
      domain_or_buffer_ctrl <= sccr_pkg::RESET_WORD;
      fault_status_or_protection <= sccr_pkg::RESET_WORD;
      prefetch_fault_status <= sccr_pkg::RESET_WORD;
      fault_address <= sccr_pkg::RESET_WORD;
      process_identifier <= sccr_pkg::RESET_WORD;
    end else begin
      system_control <= next_system_control;
      table_base_or_cache_ctrl <= next_table_base_or_cache_ctrl;
      domain_or_buffer_ctrl <= next_domain_or_buffer_ctrl;
      fault_status_or_protection <= next_fault_status_or_protection;
      prefetch_fault_status <= next_prefetch_fault_status;
      fault_address <= next_fault_address;
      process_identifier <= next_process_identifier;
    end
  end

  // ---------------------------------------------------------------
  // region definitions (protection variant)
  // ---------------------------------------------------------------
  logic region_wr; // write to region number in protection mode
  logic [31:0] region_rdata;
  assign region_wr = wr && prot_variant_i
    && req.num == sccr_pkg::REG_FADDR;

  sccr_region_bank u_region_bank (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .wr_i(region_wr),
    .index_i(region_index_selector_i),
    .wdata_i(req.data),
    .rdata_o(region_rdata)
  );

  // ---------------------------------------------------------------
  // operation registers
  // ---------------------------------------------------------------
  sccr_pkg::sccr_ops_t ops; // decoded maintenance request
  logic cache_wr;
  logic tlb_wr;
  assign cache_wr = wr && req.num == sccr_pkg::REG_CACHE_OP;
  // tlb operations exist only with translation hardware
  assign tlb_wr = wr && !prot_variant_i
    && req.num == sccr_pkg::REG_TLB_OP;

  sccr_op_decode u_op_decode (
    .cache_wr_i(cache_wr),
    .tlb_wr_i(tlb_wr),
    .wdata_i(req.data),
    .ops_o(ops)
  );

  // ---------------------------------------------------------------
  // read answer
  // ---------------------------------------------------------------
  logic [31:0] read_word; // selected read value
  always_comb begin
    read_word = '0;
    case (req.num)
      sccr_pkg::REG_IDENT: read_word = ID_VALUE;
      sccr_pkg::REG_CTRL: read_word = system_control;
      sccr_pkg::REG_TBASE: read_word = table_base_or_cache_ctrl;
      sccr_pkg::REG_DOMAIN: read_word = domain_or_buffer_ctrl;
      sccr_pkg::REG_FSTAT: begin
        if (!prot_variant_i && cache_side_selector_i) begin
          read_word = prefetch_fault_status;
        end else begin
          read_word = fault_status_or_protection;
        end
      end
      sccr_pkg::REG_FADDR: begin
        // same number, different meaning per variant
        read_word = prot_variant_i ? region_rdata : fault_address;
      end
      sccr_pkg::REG_PROC_ID: begin
        if (pid_present_i && !prot_variant_i) begin
          read_word = process_identifier;
        end
      end
      // operation registers are write-only and read zero
      default: read_word = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // output stage: answer one cycle after a read, all outputs flopped
  // ---------------------------------------------------------------
  sccr_pkg::sccr_state_t state; // answer phase
  sccr_pkg::sccr_state_t next_state;
  logic [31:0] next_rsp_rdata;
  sccr_pkg::sccr_ops_t ops_q; // registered maintenance pulses

  // read answer phase; reads may follow back to back
  always_comb begin
    next_state = sccr_pkg::SCCR_IDLE;
    next_rsp_rdata = rsp_rdata_o;
    case (state)
      sccr_pkg::SCCR_IDLE,
      sccr_pkg::SCCR_ANSWER: begin
        if (req.valid && !req.write) begin
          next_state = sccr_pkg::SCCR_ANSWER;
          next_rsp_rdata = read_word;
        end
      end
      default: next_state = sccr_pkg::SCCR_IDLE;
    endcase
  end

  // register answer and pulses
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state <= sccr_pkg::SCCR_IDLE;
      rsp_rdata_o <= sccr_pkg::RESET_WORD;
      ops_q <= '0;
    end else begin
      state <= next_state;
      rsp_rdata_o <= next_rsp_rdata;
      ops_q <= ops;
    end
  end

  assign rsp_valid_o = (state == sccr_pkg::SCCR_ANSWER);
  assign cache_inval_all_o = ops_q.cache_inval_all;
  assign tlb_inval_all_o = ops_q.tlb_inval_all;
  assign tlb_inval_one_o = ops_q.tlb_inval_one;
  assign tlb_inval_va_o = ops_q.tlb_va;
  assign system_control_o = system_control;

endmodule
`default_nettype wire

//--- sccr_regs_asserts.sv
// sccr_regs_asserts.sv - port timing checks for the register bank.
// assumes: bound to sccr_regs; one clock domain, sync active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sccr_regs_chk #(
  // identification word; value is arbitrary
  parameter logic [31:0] ID_VALUE = 32'h0000_0000
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // watched inputs
  input wire logic prot_variant_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [3:0] req_num_i,
  input wire logic [31:0] req_wdata_i,
  // watched outputs
  input wire logic rsp_valid_o,
  input wire logic [31:0] rsp_rdata_o,
  input wire logic cache_inval_all_o,
  input wire logic tlb_inval_all_o,
  input wire logic tlb_inval_one_o,
  input wire logic [31:0] tlb_inval_va_o,
  input wire logic [31:0] system_control_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------
  // request decode helpers
  // ----------------------------------------
  logic rd, wr, tlb_wr, ctl_wr;
  assign rd = req_valid_i && !req_write_i;
  assign wr = req_valid_i && req_write_i;
  // tlb register only exists in the mmu variant
  assign tlb_wr = wr && req_num_i == sccr_pkg::REG_TLB_OP && !prot_variant_i;
  assign ctl_wr = wr && req_num_i == sccr_pkg::REG_CTRL;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_read_answer: assert property (rd |=> rsp_valid_o)
    else $error("read got no answer");
  a_answer_cause: assert property (!rd |=> !rsp_valid_o)
    else $error("answer without read");
  a_id_value: assert property (rd && req_num_i == sccr_pkg::REG_IDENT
    |=> rsp_rdata_o == ID_VALUE) else $error("wrong id word");
  a_cache_flush: assert property (wr &&
    req_num_i == sccr_pkg::REG_CACHE_OP |=> cache_inval_all_o)
    else $error("cache flush missing");
  a_cache_quiet: assert property (!(wr &&
    req_num_i == sccr_pkg::REG_CACHE_OP) |=> !cache_inval_all_o)
    else $error("stray cache flush");
  a_tlb_all: assert property (tlb_wr && req_wdata_i == 32'h0000_0000
    |=> tlb_inval_all_o && !tlb_inval_one_o) else $error("tlb flush bad");
  a_tlb_one: assert property (tlb_wr && req_wdata_i[0] |=> tlb_inval_one_o
    && tlb_inval_va_o == ($past(req_wdata_i) & sccr_pkg::TLB_VA_MASK))
    else $error("tlb entry flush bad");
  a_tlb_quiet: assert property (!(tlb_wr && (req_wdata_i[0] ||
    req_wdata_i == 32'h0000_0000)) |=> !tlb_inval_all_o && !tlb_inval_one_o)
    else $error("stray tlb flush");
  a_ctrl_store: assert property (ctl_wr
    |=> system_control_o == $past(req_wdata_i)) else $error("ctrl not stored");
  a_ctrl_hold: assert property (!ctl_wr |=> $stable(system_control_o))
    else $error("ctrl changed alone");
endmodule
bind sccr_regs sccr_regs_chk #(.ID_VALUE(ID_VALUE)) i_chk (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .prot_variant_i(prot_variant_i), .req_valid_i(req_valid_i),
  .req_write_i(req_write_i), .req_num_i(req_num_i),
  .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o),
  .rsp_rdata_o(rsp_rdata_o), .cache_inval_all_o(cache_inval_all_o),
  .tlb_inval_all_o(tlb_inval_all_o), .tlb_inval_one_o(tlb_inval_one_o),
  .tlb_inval_va_o(tlb_inval_va_o), .system_control_o(system_control_o));
`default_nettype wire

//--- sccr_core_model.sv
// sccr_core_model.sv - processor core side issuing register transfers.
// assumes: bank takes a request at the edge it is valid, answers next cycle.
`timescale 1ns/1ps
`default_nettype none
module sccr_core_model (
  // clock
  input wire logic core_clk_i,
  // transfer request
  output logic req_valid_o,
  output logic req_write_o,
  output logic [3:0] req_num_o,
  output logic [31:0] req_wdata_o,
  // read answer
  input wire logic rsp_valid_i,
  input wire logic [31:0] rsp_rdata_i
);
  // idle request at time zero
  initial begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_num_o = 4'h0;
    req_wdata_o = 32'h0000_0000;
  end
  // one transfer, withdrawn just after its taking edge
  task automatic xfer(input logic w, input logic [3:0] n,
                      input logic [31:0] d);
    @(posedge core_clk_i);
    req_valid_o <= 1'b1;
    req_write_o <= w;
    req_num_o <= n;
    req_wdata_o <= d;
    @(posedge core_clk_i);
    // idle lines show the inverse so stale data cannot pass for fresh
    req_valid_o <= 1'b0;
    req_write_o <= ~w;
    req_num_o <= ~n;
    req_wdata_o <= ~d;
  endtask
  // read: answer expected in the cycle after the taking edge
  task automatic read(input logic [3:0] n, output logic [31:0] d);
    xfer(1'b0, n, 32'h0000_0000);
    @(negedge core_clk_i);
    d = (rsp_valid_i === 1'b1) ? rsp_rdata_i : 32'hxxxx_xxxx;
  endtask
endmodule
`default_nettype wire

//--- tb.sv
// tb.sv - self-checking bench for the register bank.
// assumes: sccr_core_model drives transfers; bench drives straps.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] ID_WORD = 32'h0000_5a5a; // arbitrary value
  logic core_clk_i, reset_n_i, prot, pid, side;
  logic [2:0] idx;
  logic req_valid, req_write, rsp_valid, c_all, t_all, t_one;
  logic [3:0] req_num;
  logic [31:0] req_wdata, rsp_rdata, t_va, sys_ctl, d;
  int n_errors = 0;
  int n_compared = 0;
  sccr_regs #(.ID_VALUE(ID_WORD)) i_dut (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .prot_variant_i(prot), .pid_present_i(pid),
    .cache_side_selector_i(side), .region_index_selector_i(idx),
    .req_valid_i(req_valid), .req_write_i(req_write), .req_num_i(req_num),
    .req_wdata_i(req_wdata), .rsp_valid_o(rsp_valid),
    .rsp_rdata_o(rsp_rdata), .cache_inval_all_o(c_all),
    .tlb_inval_all_o(t_all), .tlb_inval_one_o(t_one),
    .tlb_inval_va_o(t_va), .system_control_o(sys_ctl));
  sccr_core_model i_core (.core_clk_i(core_clk_i), .req_valid_o(req_valid),
    .req_write_o(req_write), .req_num_o(req_num), .req_wdata_o(req_wdata),
    .rsp_valid_i(rsp_valid), .rsp_rdata_i(rsp_rdata));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk_word(input logic [31:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %0t %s", $time, what);
      n_errors++;
    end
  endtask
  task automatic rd_chk(input logic [3:0] n, input logic [31:0] exp);
    i_core.read(n, d);
    chk_word(d, exp, "read data");
  endtask
  // write, then look at the pulses in the cycle they stand
  task automatic op_chk(input logic [3:0] n, input logic [31:0] v,
                        input logic [2:0] exp, input logic [31:0] va);
    i_core.xfer(1'b1, n, v);
    @(negedge core_clk_i);
    chk_word({29'h0, c_all, t_all, t_one}, {29'h0, exp}, "pulses");
    chk_word(t_va, va, "flush address");
  endtask
  task automatic do_reset();
    @(posedge core_clk_i) reset_n_i <= 1'b0;
    // five rising edges see reset low, this one excluded
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_mmu_store();
    logic [3:0] nums[5] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
    foreach (nums[i]) i_core.xfer(1'b1, nums[i], 32'ha5a5_0000 | i);
    foreach (nums[i]) rd_chk(nums[i], 32'ha5a5_0000 | i);
    i_core.xfer(1'b1, sccr_pkg::REG_PROC_ID, 32'h1234_5678);
    rd_chk(sccr_pkg::REG_PROC_ID, 32'h1234_5678);
    // selector reaches a second status word on number 5
    @(posedge core_clk_i) side <= 1'b1;
    i_core.xfer(1'b1, sccr_pkg::REG_FSTAT, 32'h0000_0b0b);
    rd_chk(sccr_pkg::REG_FSTAT, 32'h0000_0b0b);
    @(posedge core_clk_i) side <= 1'b0;
    rd_chk(sccr_pkg::REG_FSTAT, 32'ha5a5_0003);
    $display("done t_mmu_store");
  endtask
  task automatic t_refuse();
    logic [3:0] nums[4] = '{4'h4, 4'h9, 4'hc, 4'hf};
    i_core.xfer(1'b1, sccr_pkg::REG_IDENT, 32'hffff_ffff);
    rd_chk(sccr_pkg::REG_IDENT, ID_WORD);
    foreach (nums[i]) i_core.xfer(1'b1, nums[i], 32'hffff_ffff);
    foreach (nums[i]) rd_chk(nums[i], 32'h0000_0000);
    rd_chk(sccr_pkg::REG_CACHE_OP, 32'h0000_0000);
    rd_chk(sccr_pkg::REG_TLB_OP, 32'h0000_0000);
    @(posedge core_clk_i) pid <= 1'b0;
    rd_chk(sccr_pkg::REG_PROC_ID, 32'h0000_0000);
    @(posedge core_clk_i) pid <= 1'b1;
    $display("done t_refuse");
  endtask
  task automatic t_ops();
    op_chk(sccr_pkg::REG_CACHE_OP, 32'hffff_ffff, 3'b100, 32'h0);
    op_chk(sccr_pkg::REG_TLB_OP, 32'h0000_0000, 3'b010, 32'h0);
    op_chk(sccr_pkg::REG_TLB_OP, 32'h0000_1001, 3'b001, 32'h1000);
    op_chk(sccr_pkg::REG_TLB_OP, 32'h0000_1002, 3'b000, 32'h0);
    $display("done t_ops");
  endtask
  task automatic t_reset_again();
    do_reset();
    chk_word(sys_ctl, 32'h0000_0000, "ctrl after reset");
    rd_chk(sccr_pkg::REG_TBASE, 32'h0000_0000);
    $display("done t_reset_again");
  endtask
  task automatic t_prot();
    logic [3:0] nums[4] = '{4'h1, 4'h2, 4'h3, 4'h5};
    @(posedge core_clk_i) prot <= 1'b1;
    foreach (nums[i]) i_core.xfer(1'b1, nums[i], 32'h5a00_0000 | i);
    foreach (nums[i]) rd_chk(nums[i], 32'h5a00_0000 | i);
    // every region keeps its own base, size and enable
    for (int i = 0; i < sccr_pkg::REGION_COUNT; i++) begin
      @(posedge core_clk_i) idx <= 3'(i);
      i_core.xfer(1'b1, sccr_pkg::REG_FADDR, ~(32'(i) << 13 | 32'(i) << 1));
    end
    for (int i = 0; i < sccr_pkg::REGION_COUNT; i++) begin
      @(posedge core_clk_i) idx <= 3'(i);
      rd_chk(sccr_pkg::REG_FADDR, ~(32'(i) << 13 | 32'(i) << 1)
             & 32'hffff_f03f);
    end
    op_chk(sccr_pkg::REG_TLB_OP, 32'h0000_0000, 3'b000, 32'h0);
    op_chk(sccr_pkg::REG_CACHE_OP, 32'h0000_0000, 3'b100, 32'h0);
    $display("done t_prot");
  endtask
  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // whole run needs about 150 cycles
  initial begin
    repeat (4000) @(posedge core_clk_i);
    n_errors++;
    end_of_test();
  end
  initial begin
    reset_n_i = 1'b0;
    prot = 1'b0;
    pid = 1'b1;
    side = 1'b0;
    idx = 3'h0;
    do_reset();
    chk_word(sys_ctl, 32'h0000_0000, "ctrl at reset");
    t_mmu_store();
    t_refuse();
    t_ops();
    t_reset_again();
    t_prot();
    end_of_test();
  end
endmodule
`default_nettype wire
